// ==== verilog/power_ctrl_regs.sv ====
// System power and control register bank: sleep control, timed-sequence bits,
// pull-up disable, vector relocation and peripheral clock gating.
// Assumes the core presents one-cycle read/write strobes synchronous to I_CLK.
//
// Behaviour
// - Sleep instruction enters selected mode only while sleep enable is one.
// - Test port enabled when disable bit zero and fuse programmed.
// - Test-port disable changes only on two equal writes within four cycles.
// - Brown-out sleep-off set by enable write then disable-only write within four.
// - Brown-out sleep-off effective three cycles after set; sleep then stops detector.
// - Hardware clears brown-out sleep-off four cycles after it is set.
// - Pull-up disable forces every port pull-up off.
// - Vector select zero: table at flash start; one: boot section base.
// - Vector select changes by change-enable write, then value within four cycles.
// - Interrupts blocked from change-enable until after next instruction or four cycles.
// - Change enable cleared four cycles after write or on vector-select write.
// - Lock bits block interrupts in the section not holding the vectors.
// - Gating register 0 bits stop their module clocks.
// - Timer two gate acts only in synchronous clock mode.
// - Re-enabled timers resume from their frozen state.
// - Gated converter denies comparator access to its input multiplexer.
// - Gating register 1 bit 0 stops timer three clock.
// - Low I/O registers reachable at offset minus 0x20; 0x60 up data-space only.
// - Sleep mode codes: idle, noise, down, save, standby, extended; 100/101 reserved.
module power_ctrl_regs
  import power_ctrl_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire bus_req_s I_BUS,
  input wire logic I_SLEEP_INSTR,
  input wire logic I_INSTR_DONE,
  input wire logic I_TEST_PORT_FUSE,
  input wire logic I_TIMER_TWO_ASYNC_SELECT,
  input wire logic I_APP_PROTECT_LOCK,
  input wire logic I_BOOT_PROTECT_LOCK,
  input wire logic I_EXEC_IN_BOOT,
  input wire logic [15:0] I_BOOT_BASE,
  output logic [7:0] O_RDATA,
  output logic O_SLEEP_ENTER,
  output sleep_mode_e O_SLEEP_MODE,
  output logic O_BOD_OFF_IN_SLEEP,
  output logic O_TEST_PORT_ENABLE,
  output logic O_PULLUP_DISABLE,
  output logic [15:0] O_VECTOR_BASE,
  output logic O_IRQ_BLOCK,
  output gates_s O_CLK_STOP,
  output logic O_COMPARATOR_MUX_ALLOW
);
  logic [7:0] sleep_ctrl, next_sleep_ctrl;
  logic test_off, next_test_off;
  logic bod_off, next_bod_off;
  logic bod_off_en, next_bod_off_en;
  logic pullup_off, next_pullup_off;
  logic vsel, next_vsel;
  logic vce, next_vce;
  logic [7:0] gate0, next_gate0;
  logic gate1, next_gate1;
  logic [2:0] test_off_cnt, next_test_off_cnt;
  logic test_off_val, next_test_off_val;
  logic [2:0] bod_en_cnt, next_bod_en_cnt;
  logic [2:0] bod_off_cnt, next_bod_off_cnt;
  logic [2:0] vce_cnt, next_vce_cnt;
  logic blk_after, next_blk_after;
  logic [7:0] rdata, next_rdata;
  logic sel_sleep, sel_mcu, sel_g0, sel_g1, wr_mcu;
  logic [7:0] dsa;
  logic [7:0] wd;
  sleep_mode_e mode;
  logic mode_ok;

  // I/O instructions carry the address less the offset; extended space is unreachable that way
  always_comb
  begin
    dsa = I_BUS.addr;
    if (I_BUS.io_space)
    begin
      dsa = I_BUS.addr + IO_OFFSET;
    end
    sel_sleep = (dsa == SLEEP_MODE_CONTROL_ADDR);
    sel_mcu = (dsa == MCU_CONTROL_ADDR);
    sel_g0 = !I_BUS.io_space && (I_BUS.addr == CLOCK_GATING_0_ADDR);
    sel_g1 = !I_BUS.io_space && (I_BUS.addr == CLOCK_GATING_1_ADDR);
    if (I_BUS.io_space && I_BUS.addr >= EXT_IO_BASE - IO_OFFSET)
    begin
      sel_sleep = 1'b0;
      sel_mcu = 1'b0;
    end
    wd = I_BUS.wdata;
    wr_mcu = I_BUS.wr && sel_mcu;
  end

  always_comb
  begin
    mode_ok = 1'b1;
    unique case (sleep_ctrl[SLEEP_SEL_LSB +: 3])
      3'h0: mode = MODE_IDLE;
      3'h1: mode = MODE_NOISE_REDUCTION;
      3'h2: mode = MODE_POWER_DOWN;
      3'h3: mode = MODE_POWER_SAVE;
      3'h6: mode = MODE_STANDBY;
      3'h7: mode = MODE_EXT_STANDBY;
      default:
      begin
        mode = MODE_IDLE;
        mode_ok = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    next_sleep_ctrl = sleep_ctrl;
    next_test_off = test_off;
    next_bod_off = bod_off;
    next_bod_off_en = bod_off_en;
    next_pullup_off = pullup_off;
    next_vsel = vsel;
    next_vce = vce;
    next_gate0 = gate0;
    next_gate1 = gate1;
    next_test_off_cnt = (test_off_cnt != 3'h0) ? test_off_cnt - 3'h1 : 3'h0;
    next_test_off_val = test_off_val;
    next_bod_en_cnt = (bod_en_cnt != 3'h0) ? bod_en_cnt - 3'h1 : 3'h0;
    next_bod_off_cnt = (bod_off_cnt != 3'h0) ? bod_off_cnt - 3'h1 : 3'h0;
    next_vce_cnt = (vce_cnt != 3'h0) ? vce_cnt - 3'h1 : 3'h0;
    next_blk_after = 1'b0;
    next_rdata = 8'h00;
    if (bod_en_cnt == 3'h1)
    begin
      next_bod_off_en = 1'b0;
    end
    if (bod_off_cnt == 3'h1)
    begin
      next_bod_off = 1'b0;
    end
    if (vce_cnt == 3'h1)
    begin
      next_vce = 1'b0;
    end
    if (blk_after && !I_INSTR_DONE)
    begin
      next_blk_after = 1'b1;
    end
    if (I_BUS.wr && sel_sleep)
    begin
      next_sleep_ctrl = wd & SLEEP_CTRL_MASK;
    end
    if (I_BUS.wr && sel_g0)
    begin
      next_gate0 = wd;
    end
    if (I_BUS.wr && sel_g1)
    begin
      next_gate1 = wd[GATE_TIMER_THREE_BIT];
    end
    if (wr_mcu)
    begin
      next_pullup_off = wd[PULLUP_OFF_POS];
      // Second matching write inside the window commits; otherwise rearm
      if (test_off_cnt != 3'h0 && test_off_val == wd[TEST_OFF_POS])
      begin
        next_test_off = wd[TEST_OFF_POS];
        next_test_off_cnt = 3'h0;
      end
      else
      begin
        next_test_off_val = wd[TEST_OFF_POS];
        next_test_off_cnt = WINDOW_CYCLES;
      end
      if (wd[BOD_OFF_POS] && wd[BOD_OFF_EN_POS])
      begin
        next_bod_off_en = 1'b1;
        next_bod_en_cnt = WINDOW_CYCLES;
      end
      else if (bod_off_en && wd[BOD_OFF_POS] && !wd[BOD_OFF_EN_POS])
      begin
        next_bod_off = 1'b1;
        next_bod_off_cnt = BOD_OFF_CYCLES + 3'h1;
        next_bod_off_en = 1'b0;
        next_bod_en_cnt = 3'h0;
      end
      if (wd[VCE_BIT])
      begin
        next_vce = 1'b1;
        next_vce_cnt = WINDOW_CYCLES;
      end
      else if (vce)
      begin
        next_vsel = wd[VSEL_BIT];
        next_vce = 1'b0;
        next_vce_cnt = 3'h0;
        next_blk_after = 1'b1;
      end
    end
    if (I_BUS.rd)
    begin
      if (sel_sleep)
      begin
        next_rdata = sleep_ctrl;
      end
      else if (sel_mcu)
      begin
        next_rdata = {test_off, bod_off, bod_off_en, pullup_off, 2'h0, vsel, vce} & MCU_CTRL_MASK;
      end
      else if (sel_g0)
      begin
        next_rdata = gate0;
      end
      else if (sel_g1)
      begin
        next_rdata = {7'h00, gate1} & GATE1_MASK;
      end
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      sleep_ctrl <= SLEEP_MODE_CONTROL_RESET;
      {test_off, bod_off, bod_off_en, pullup_off} <= MCU_CONTROL_RESET[7:4];
      vsel <= MCU_CONTROL_RESET[VSEL_BIT];
      vce <= MCU_CONTROL_RESET[VCE_BIT];
      gate0 <= CLOCK_GATING_0_RESET;
      gate1 <= CLOCK_GATING_1_RESET[GATE_TIMER_THREE_BIT];
      test_off_cnt <= 3'h0;
      test_off_val <= 1'b0;
      bod_en_cnt <= 3'h0;
      bod_off_cnt <= 3'h0;
      vce_cnt <= 3'h0;
      blk_after <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      sleep_ctrl <= next_sleep_ctrl;
      test_off <= next_test_off;
      bod_off <= next_bod_off;
      bod_off_en <= next_bod_off_en;
      pullup_off <= next_pullup_off;
      vsel <= next_vsel;
      vce <= next_vce;
      gate0 <= next_gate0;
      gate1 <= next_gate1;
      test_off_cnt <= next_test_off_cnt;
      test_off_val <= next_test_off_val;
      bod_en_cnt <= next_bod_en_cnt;
      bod_off_cnt <= next_bod_off_cnt;
      vce_cnt <= next_vce_cnt;
      blk_after <= next_blk_after;
      rdata <= next_rdata;
    end
  end

  // Registered outputs; all but O_IRQ_BLOCK, which also decodes next-state terms, lag the register state by one cycle
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      O_RDATA <= 8'h00;
      O_SLEEP_ENTER <= 1'b0;
      O_SLEEP_MODE <= MODE_IDLE;
      O_BOD_OFF_IN_SLEEP <= 1'b0;
      O_TEST_PORT_ENABLE <= 1'b0;
      O_PULLUP_DISABLE <= 1'b0;
      O_VECTOR_BASE <= 16'h0000;
      O_IRQ_BLOCK <= 1'b0;
      O_CLK_STOP <= '0;
      O_COMPARATOR_MUX_ALLOW <= 1'b1;
    end
    else
    begin
      O_RDATA <= rdata;
      // Reserved codes are refused rather than guessed at
      O_SLEEP_ENTER <= I_SLEEP_INSTR && sleep_ctrl[SLEEP_EN_POS] && mode_ok;
      O_SLEEP_MODE <= mode;
      // Effective only once the three-cycle arming delay has run out
      O_BOD_OFF_IN_SLEEP <= I_SLEEP_INSTR && sleep_ctrl[SLEEP_EN_POS] && bod_off
        && bod_off_cnt == 3'h1;
      O_TEST_PORT_ENABLE <= !test_off && I_TEST_PORT_FUSE;
      O_PULLUP_DISABLE <= pullup_off;
      O_VECTOR_BASE <= vsel ? I_BOOT_BASE : 16'h0000;
      O_IRQ_BLOCK <= next_vce || vce || blk_after || next_blk_after
        || (vsel && I_APP_PROTECT_LOCK && !I_EXEC_IN_BOOT)
        || (!vsel && I_BOOT_PROTECT_LOCK && I_EXEC_IN_BOOT);
      O_CLK_STOP.gate0 <= gate0 & ~{1'b0, I_TIMER_TWO_ASYNC_SELECT, 6'h00};
      O_CLK_STOP.gate1 <= gate1;
      O_COMPARATOR_MUX_ALLOW <= !gate0[GATE_CONVERTER_BIT];
    end
  end
endmodule

// ==== verilog/power_ctrl_pkg.sv ====
// Package for the system power and control register bank.
// Assumes a byte-wide core data bus with data-space addressing.
package power_ctrl_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam logic [7:0] IO_OFFSET = 8'h20;
  localparam logic [7:0] EXT_IO_BASE = 8'h60;
  localparam logic [7:0] SLEEP_MODE_CONTROL_ADDR = 8'h53;
  localparam logic [7:0] MCU_CONTROL_ADDR = 8'h55;
  localparam logic [7:0] CLOCK_GATING_0_ADDR = 8'h64;
  localparam logic [7:0] CLOCK_GATING_1_ADDR = 8'h65;
  localparam logic [7:0] SLEEP_MODE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] MCU_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CLOCK_GATING_0_RESET = 8'h00;
  localparam logic [7:0] CLOCK_GATING_1_RESET = 8'h00;
  localparam int SLEEP_EN_POS = 0;
  localparam int SLEEP_SEL_LSB = 1;
  localparam int TEST_OFF_POS = 7;
  localparam int BOD_OFF_POS = 6;
  localparam int BOD_OFF_EN_POS = 5;
  localparam int PULLUP_OFF_POS = 4;
  localparam int VSEL_BIT = 1;
  localparam int VCE_BIT = 0;
  localparam int GATE_TIMER_TWO_BIT = 6;
  localparam int GATE_CONVERTER_BIT = 0;
  localparam int GATE_TIMER_THREE_BIT = 0;
  localparam logic [2:0] WINDOW_CYCLES = 3'h4;
  localparam logic [2:0] BOD_OFF_CYCLES = 3'h3;
  localparam logic [7:0] SLEEP_CTRL_MASK = 8'h0F;
  localparam logic [7:0] MCU_CTRL_MASK = 8'hF3;
  localparam logic [7:0] GATE1_MASK = 8'h01;

  typedef enum logic [5:0] {
    MODE_IDLE = 6'h01,
    MODE_NOISE_REDUCTION = 6'h02,
    MODE_POWER_DOWN = 6'h04,
    MODE_POWER_SAVE = 6'h08,
    MODE_STANDBY = 6'h10,
    MODE_EXT_STANDBY = 6'h20
  } sleep_mode_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic io_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic [7:0] gate0;
    logic gate1;
  } gates_s;
endpackage

// ==== tb/power_ctrl_regs_properties.sv ====
// Port-level properties of the power and control register bank.
// Assumes the bench holds the lock inputs low while it times the vector window.
module power_ctrl_regs_properties
  import power_ctrl_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire bus_req_s I_BUS,
  input wire logic I_SLEEP_INSTR,
  input wire logic I_INSTR_DONE,
  input wire logic I_TEST_PORT_FUSE,
  input wire logic I_TIMER_TWO_ASYNC_SELECT,
  input wire logic I_APP_PROTECT_LOCK,
  input wire logic I_BOOT_PROTECT_LOCK,
  input wire logic [7:0] O_RDATA,
  input wire logic O_SLEEP_ENTER,
  input wire sleep_mode_e O_SLEEP_MODE,
  input wire logic O_BOD_OFF_IN_SLEEP,
  input wire logic O_TEST_PORT_ENABLE,
  input wire logic O_IRQ_BLOCK,
  input wire gates_s O_CLK_STOP,
  input wire logic O_COMPARATOR_MUX_ALLOW
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  logic nolock;
  logic vce_wr;
  logic quiet;
  assign nolock = !I_APP_PROTECT_LOCK && !I_BOOT_PROTECT_LOCK;
  assign vce_wr = I_BUS.wr && !I_BUS.io_space && I_BUS.addr == MCU_CONTROL_ADDR
    && I_BUS.wdata == 8'h01 && nolock;
  assign quiet = !I_BUS.wr && !I_INSTR_DONE && nolock;
  chk_sleep_cause: assert property (O_SLEEP_ENTER |-> $past(I_SLEEP_INSTR))
    else $error("sleep entry without instruction");
  chk_mode_onehot: assert property (O_SLEEP_ENTER |-> $onehot(O_SLEEP_MODE))
    else $error("sleep entry with bad mode");
  chk_bod_in_sleep: assert property (O_BOD_OFF_IN_SLEEP |-> O_SLEEP_ENTER)
    else $error("detector off without sleep");
  chk_fuse_off: assert property (!I_TEST_PORT_FUSE [*2] |-> !O_TEST_PORT_ENABLE)
    else $error("test port on without fuse");
  chk_vce_blocks: assert property (vce_wr |=> O_IRQ_BLOCK)
    else $error("change enable did not block");
  chk_block_expires: assert property (vce_wr ##1 quiet [*5] |=> !O_IRQ_BLOCK)
    else $error("block outlived window");
  chk_adc_mux: assert property (O_CLK_STOP.gate0[0] [*2] |-> !O_COMPARATOR_MUX_ALLOW)
    else $error("mux open while converter gated");
  chk_t2_async: assert property (I_TIMER_TWO_ASYNC_SELECT [*2] |-> !O_CLK_STOP.gate0[6])
    else $error("timer two stopped in async mode");
  chk_rdata_idle: assert property (O_RDATA != 8'h00 |-> $past(I_BUS.rd, 2))
    else $error("read data without read");
  cover property (O_BOD_OFF_IN_SLEEP);
  cover property ($fell(O_IRQ_BLOCK));
  cover property (O_SLEEP_ENTER && O_SLEEP_MODE == MODE_EXT_STANDBY);
endmodule

bind power_ctrl_regs power_ctrl_regs_properties u_props (.I_CLK, .I_SRST, .I_BUS,
  .I_SLEEP_INSTR, .I_INSTR_DONE, .I_TEST_PORT_FUSE, .I_TIMER_TWO_ASYNC_SELECT,
  .I_APP_PROTECT_LOCK, .I_BOOT_PROTECT_LOCK, .O_RDATA, .O_SLEEP_ENTER, .O_SLEEP_MODE,
  .O_BOD_OFF_IN_SLEEP, .O_TEST_PORT_ENABLE, .O_IRQ_BLOCK, .O_CLK_STOP,
  .O_COMPARATOR_MUX_ALLOW);

// ==== tb/power_ctrl_regs_tb.sv ====
// Self-checking bench for the power and control register bank.
// Drives one-cycle strobes on falling edges; reads land two cycles later.
module power_ctrl_regs_tb
  import power_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  bus_req_s bus = '0;
  logic sleep_instr = 1'b0, instr_done = 1'b0, fuse = 1'b1, async_sel = 1'b0;
  logic app_lock = 1'b0, boot_lock = 1'b0, in_boot = 1'b0;
  logic [15:0] boot_base = 16'h1E00;
  logic [7:0] rdata;
  logic enter, bod_off, tp_en, pu_off, irq_block, mux_allow;
  logic [15:0] vbase;
  sleep_mode_e mode;
  gates_s stop;
  int mismatches = 0, n_tests = 0, hits;
  sleep_mode_e tab [8] = '{MODE_IDLE, MODE_NOISE_REDUCTION, MODE_POWER_DOWN,
    MODE_POWER_SAVE, MODE_IDLE, MODE_IDLE, MODE_STANDBY, MODE_EXT_STANDBY};
  power_ctrl_regs DUT (.I_CLK(clk), .I_SRST(srst), .I_BUS(bus), .I_SLEEP_INSTR(sleep_instr),
    .I_INSTR_DONE(instr_done), .I_TEST_PORT_FUSE(fuse), .I_TIMER_TWO_ASYNC_SELECT(async_sel),
    .I_APP_PROTECT_LOCK(app_lock), .I_BOOT_PROTECT_LOCK(boot_lock), .I_EXEC_IN_BOOT(in_boot),
    .I_BOOT_BASE(boot_base), .O_RDATA(rdata), .O_SLEEP_ENTER(enter), .O_SLEEP_MODE(mode),
    .O_BOD_OFF_IN_SLEEP(bod_off), .O_TEST_PORT_ENABLE(tp_en), .O_PULLUP_DISABLE(pu_off),
    .O_VECTOR_BASE(vbase), .O_IRQ_BLOCK(irq_block), .O_CLK_STOP(stop),
    .O_COMPARATOR_MUX_ALLOW(mux_allow));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic io, input logic [7:0] a, d);
    bus = '{1'b1, 1'b0, io, a, d};
    @(negedge clk);
  endtask
  task automatic idle(input int n);
    bus = '0;
    repeat (n) @(negedge clk);
  endtask
  task automatic rd(input logic io, input logic [7:0] a, exp);
    bus = '{1'b0, 1'b1, io, a, 8'h00};
    @(negedge clk);
    bus = '0;
    // Read data is two register stages behind the strobe
    @(negedge clk);
    chk(rdata, exp);
  endtask
  // Outputs are sampled at the falling edge after the edge that took the pulse
  task automatic sleep_pulse(output logic e, b);
    sleep_instr = 1'b1;
    @(negedge clk);
    sleep_instr = 1'b0;
    e = enter;
    b = bod_off;
    @(negedge clk);
  endtask
  task automatic done_pulse;
    instr_done = 1'b1;
    @(negedge clk);
    instr_done = 1'b0;
    idle(2);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end
  initial
  begin
    logic e, b;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk(mode, MODE_IDLE);
    chk(mux_allow, 1'b1);
    rd(1'b1, 8'h35, 8'h00);
    rd(1'b0, 8'h70, 8'h00);
    for (int i = 0; i < 16; i++)
    begin
      wr(1'b1, 8'h33, {4'hF, 4'(i)});
      idle(1);
      rd(1'b0, 8'h53, {4'h0, 4'(i)});
      sleep_pulse(e, b);
      chk(e, i[0] && i[3:1] != 3'h4 && i[3:1] != 3'h5);
      if (e === 1'b1)
        chk(mode, tab[i[3:1]]);
    end
    wr(1'b0, 8'h55, 8'h80);
    idle(2);
    chk(tp_en, 1'b1);
    wr(1'b0, 8'h55, 8'h80);
    wr(1'b0, 8'h55, 8'h80);
    idle(2);
    chk(tp_en, 1'b0);
    rd(1'b1, 8'h35, 8'h80);
    wr(1'b0, 8'h55, 8'h00);
    idle(4);
    wr(1'b0, 8'h55, 8'h00);
    idle(1);
    wr(1'b0, 8'h55, 8'h00);
    idle(2);
    chk(tp_en, 1'b1);
    fuse = 1'b0;
    idle(2);
    chk(tp_en, 1'b0);
    fuse = 1'b1;
    wr(1'b0, 8'h55, 8'h10);
    idle(2);
    chk(pu_off, 1'b1);
    rd(1'b1, 8'h35, 8'h10);
    wr(1'b0, 8'h55, 8'h00);
    idle(2);
    chk(pu_off, 1'b0);
    wr(1'b0, 8'h53, 8'h05);
    for (int a = 0; a < 2; a++)
    begin
      hits = 0;
      for (int d = 1; d < 7; d++)
      begin
        if (a == 0)
          wr(1'b0, 8'h55, 8'h60);
        wr(1'b0, 8'h55, 8'h40);
        idle(d);
        sleep_pulse(e, b);
        hits += int'(b === 1'b1);
        idle(6);
      end
      chk(16'(hits), a == 0 ? 16'h0001 : 16'h0000);
    end
    rd(1'b0, 8'h55, 8'h00);
    wr(1'b0, 8'h55, 8'h01);
    wr(1'b0, 8'h55, 8'h02);
    idle(2);
    chk(vbase, boot_base);
    chk(irq_block, 1'b1);
    done_pulse();
    chk(irq_block, 1'b0);
    app_lock = 1'b1;
    idle(2);
    chk(irq_block, 1'b1);
    in_boot = 1'b1;
    idle(2);
    chk(irq_block, 1'b0);
    app_lock = 1'b0;
    wr(1'b0, 8'h55, 8'h01);
    idle(6);
    chk(irq_block, 1'b0);
    wr(1'b0, 8'h55, 8'h00);
    idle(2);
    chk(vbase, boot_base);
    rd(1'b0, 8'h55, 8'h02);
    wr(1'b0, 8'h55, 8'h01);
    wr(1'b0, 8'h55, 8'h00);
    done_pulse();
    chk(vbase, 16'h0000);
    boot_lock = 1'b1;
    idle(2);
    chk(irq_block, 1'b1);
    boot_lock = 1'b0;
    async_sel = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      wr(1'b0, 8'h64, 8'h01 << k);
      idle(2);
      rd(1'b0, 8'h64, 8'h01 << k);
      chk(stop.gate0, k == 6 ? 8'h00 : 8'h01 << k);
      chk(mux_allow, k != 0);
    end
    async_sel = 1'b0;
    wr(1'b0, 8'h64, 8'h40);
    idle(2);
    chk(stop.gate0, 8'h40);
    wr(1'b0, 8'h65, 8'hFF);
    idle(2);
    rd(1'b0, 8'h65, 8'h01);
    chk(stop.gate1, 1'b1);
    wr(1'b1, 8'h44, 8'hFF);
    idle(2);
    rd(1'b0, 8'h64, 8'h40);
    conclude();
  end
endmodule
